// [rtl/pwmc_defines.svh]
`ifndef PWMC_DEFINES_SVH
`define PWMC_DEFINES_SVH

// register byte addresses
`define PWMC_ADR_CTRL0 8'h00
`define PWMC_ADR_DCH0 8'h04
`define PWMC_ADR_DCL0 8'h08
`define PWMC_ADR_CTRL1 8'h0C
`define PWMC_ADR_DCH1 8'h10
`define PWMC_ADR_DCL1 8'h14
`define PWMC_ADR_PLIM 8'h18
`define PWMC_ADR_PCNT 8'h1C
`define PWMC_ADR_TCFG 8'h20

// control field positions
`define PWMC_CTL_EN 7
`define PWMC_CTL_OE 6
`define PWMC_CTL_OUT 5
`define PWMC_CTL_POL 4
`define PWMC_DCL_MSB 7
`define PWMC_DCL_LSB 6

// timer config field positions
`define PWMC_TCFG_ON 0
`define PWMC_TCFG_SLEEP 1
`define PWMC_TCFG_PS_LSB 2
`define PWMC_TCFG_PS_MSB 3

// reset values
`define PWMC_CTRL_RST 4'h0
`define PWMC_PLIM_RST 8'hFF
`define PWMC_ZERO8 8'h00
`define PWMC_ZERO2 2'h0
`define PWMC_ZERO10 10'h000
`define PWMC_ZERO32 32'h0000_0000

// prescale terminal counts (1:1, 1:4, 1:16, 1:64) minus one
`define PWMC_PS1 6'h00
`define PWMC_PS4 6'h03
`define PWMC_PS16 6'h0F
`define PWMC_PS64 6'h3F

`endif

// [rtl/pwmc_pkg.sv]
package pwmc_pkg;

	typedef struct packed {
		logic en;
		logic oe;
		logic pol;
		logic [7:0] dch;
		logic [1:0] dcl;
		logic [9:0] duty_act;
		logic wave;
		logic pin;
		logic pin_oe;
	} pwmc_chan_t;

endpackage : pwmc_pkg

// [rtl/pwmc_top.sv]
// Functional notes
// R01: control bit 6 routes waveform onto pin
// R02: control bit 5 reads live output level
// R03: control bit 4 inverts output polarity
// R04: control bits 3..0 read zero, ignore writes
// R05: high duty byte fully read/write
// R06: low register bits 7..6 are duty LSBs
// R07: low register bits 5..0 read zero
// R08: reset clears control, duty registers keep value
// R09: control bit 7 enables channel, else inactive
// R10: two channels share one counter and limit
// R11: set at restart unless zero, clear on match
// R12: duty buffers load after counter hits limit
// R13: time base is counter plus two prescaled bits
// R14: sleep freezes counter, channels and pin
//
// The implementer's own choices: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
`include "pwmc_defines.svh"

module pwmc_top #(
	parameter int NUM_CH = 2
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic [NUM_CH-1:0] pwm_pin_o,
	output logic [NUM_CH-1:0] pwm_pin_oe_o
);

	typedef struct packed {
		pwmc_pkg::pwmc_chan_t [NUM_CH-1:0] ch;
		logic [7:0] plim;
		logic [7:0] pcnt;
		logic [1:0] sub;
		logic [5:0] ps_cnt;
		logic t_on;
		logic sleep;
		logic [1:0] ps_sel;
		logic reload;
		logic ack;
		logic [31:0] rdat;
	} pwmc_state_t;

	pwmc_state_t st_ff;
	pwmc_state_t nxt_st;

	// prescale terminal count from select field
	function automatic logic [5:0] ps_limit(input logic [1:0] sel);
		unique case (sel)
			2'h0: ps_limit = `PWMC_PS1;
			2'h1: ps_limit = `PWMC_PS4;
			2'h2: ps_limit = `PWMC_PS16;
			2'h3: ps_limit = `PWMC_PS64;
		endcase
	endfunction : ps_limit

	function automatic logic [7:0] ctrl_byte(input pwmc_pkg::pwmc_chan_t c);
		ctrl_byte = `PWMC_ZERO8;
		ctrl_byte[`PWMC_CTL_EN] = c.en;
		ctrl_byte[`PWMC_CTL_OE] = c.oe;
		ctrl_byte[`PWMC_CTL_OUT] = c.pin; // [R02]
		ctrl_byte[`PWMC_CTL_POL] = c.pol; // [R03]
	endfunction : ctrl_byte

	logic acc;
	logic wr;
	logic tick;
	logic [9:0] tbase;
	logic restart;
	logic [31:0] rd;

	always_comb begin
		nxt_st = st_ff;
		acc = wb_cyc_i && wb_stb_i && !st_ff.ack;
		// writes land on the edge where the master sees ack high
		wr = wb_cyc_i && wb_stb_i && st_ff.ack && wb_we_i && wb_sel_i[0];
		rd = `PWMC_ZERO32;
		nxt_st.ack = acc;
		// sleep holds everything in the time base still
		tick = st_ff.t_on && !st_ff.sleep && (st_ff.ps_cnt == ps_limit(st_ff.ps_sel)); // [R14]
		tbase = {st_ff.pcnt, st_ff.sub}; // [R13]
		restart = 1'b0;
		nxt_st.reload = 1'b0;
		if (st_ff.t_on && !st_ff.sleep) begin // [R14]
			nxt_st.ps_cnt = tick ? 6'h00 : st_ff.ps_cnt + 6'h01;
		end
		if (tick) begin
			nxt_st.sub = st_ff.sub + 2'h1; // [R13]
			if (st_ff.sub == 2'h3) begin
				if (st_ff.pcnt == st_ff.plim) begin
					nxt_st.pcnt = `PWMC_ZERO8;
					nxt_st.reload = 1'b1; // [R12]
				end else begin
					nxt_st.pcnt = st_ff.pcnt + 8'h01;
				end
			end
		end
		restart = st_ff.reload;
		for (int i = 0; i < NUM_CH; i++) begin // [R10]
			// buffers only move at period boundary, avoiding torn duty values
			if (restart) begin
				nxt_st.ch[i].duty_act = {st_ff.ch[i].dch, st_ff.ch[i].dcl}; // [R12] [R06]
				nxt_st.ch[i].wave = ({st_ff.ch[i].dch, st_ff.ch[i].dcl} != `PWMC_ZERO10); // [R11]
			end else if (tick && tbase == st_ff.ch[i].duty_act
					&& st_ff.ch[i].duty_act[9:2] <= st_ff.plim) begin
				nxt_st.ch[i].wave = 1'b0; // [R11]
			end
			if (!st_ff.sleep) begin // [R14]
				nxt_st.ch[i].pin = st_ff.ch[i].en
					? (st_ff.ch[i].wave ^ st_ff.ch[i].pol) // [R03] [R09]
					: st_ff.ch[i].pol; // [R09]
				nxt_st.ch[i].pin_oe = st_ff.ch[i].oe; // [R01]
			end
		end
		// register reads
		unique case (wb_adr_i)
			`PWMC_ADR_CTRL0: rd[7:0] = ctrl_byte(st_ff.ch[0]); // [R04]
			`PWMC_ADR_DCH0: rd[7:0] = st_ff.ch[0].dch; // [R05]
			`PWMC_ADR_DCL0: rd[7:6] = st_ff.ch[0].dcl; // [R07]
			`PWMC_ADR_CTRL1: rd[7:0] = ctrl_byte(st_ff.ch[1]);
			`PWMC_ADR_DCH1: rd[7:0] = st_ff.ch[1].dch;
			`PWMC_ADR_DCL1: rd[7:6] = st_ff.ch[1].dcl;
			`PWMC_ADR_PLIM: rd[7:0] = st_ff.plim;
			`PWMC_ADR_PCNT: rd[7:0] = st_ff.pcnt;
			`PWMC_ADR_TCFG: begin
				rd[`PWMC_TCFG_ON] = st_ff.t_on;
				rd[`PWMC_TCFG_SLEEP] = st_ff.sleep;
				rd[`PWMC_TCFG_PS_MSB:`PWMC_TCFG_PS_LSB] = st_ff.ps_sel;
			end
			default: rd = `PWMC_ZERO32;
		endcase
		if (acc) begin
			nxt_st.rdat = rd;
		end
		// register writes, byte lane 0 only; low bits dropped
		if (wr) begin
			unique case (wb_adr_i)
				`PWMC_ADR_CTRL0, `PWMC_ADR_CTRL1: begin
					for (int i = 0; i < NUM_CH; i++) begin
						if (wb_adr_i == ((i == 0) ? `PWMC_ADR_CTRL0 : `PWMC_ADR_CTRL1)) begin
							nxt_st.ch[i].en = wb_dat_i[`PWMC_CTL_EN]; // [R09]
							nxt_st.ch[i].oe = wb_dat_i[`PWMC_CTL_OE]; // [R01]
							nxt_st.ch[i].pol = wb_dat_i[`PWMC_CTL_POL]; // [R03] [R04]
						end
					end
				end
				`PWMC_ADR_DCH0: nxt_st.ch[0].dch = wb_dat_i[7:0]; // [R05]
				`PWMC_ADR_DCL0: nxt_st.ch[0].dcl = wb_dat_i[`PWMC_DCL_MSB:`PWMC_DCL_LSB]; // [R06] [R07]
				`PWMC_ADR_DCH1: nxt_st.ch[1].dch = wb_dat_i[7:0];
				`PWMC_ADR_DCL1: nxt_st.ch[1].dcl = wb_dat_i[`PWMC_DCL_MSB:`PWMC_DCL_LSB];
				`PWMC_ADR_PLIM: nxt_st.plim = wb_dat_i[7:0];
				`PWMC_ADR_PCNT: begin
					nxt_st.pcnt = wb_dat_i[7:0];
					nxt_st.sub = `PWMC_ZERO2;
				end
				`PWMC_ADR_TCFG: begin
					nxt_st.t_on = wb_dat_i[`PWMC_TCFG_ON];
					nxt_st.sleep = wb_dat_i[`PWMC_TCFG_SLEEP];
					nxt_st.ps_sel = wb_dat_i[`PWMC_TCFG_PS_MSB:`PWMC_TCFG_PS_LSB];
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_ff <= nxt_st;
			// duty holding and active values survive reset
			for (int i = 0; i < NUM_CH; i++) begin
				st_ff.ch[i].en <= 1'b0; // [R08]
				st_ff.ch[i].oe <= 1'b0; // [R08]
				st_ff.ch[i].pol <= 1'b0; // [R08]
				st_ff.ch[i].dch <= st_ff.ch[i].dch; // [R08]
				st_ff.ch[i].dcl <= st_ff.ch[i].dcl; // [R08]
				st_ff.ch[i].duty_act <= st_ff.ch[i].duty_act;
				st_ff.ch[i].wave <= 1'b0;
				st_ff.ch[i].pin <= 1'b0;
				st_ff.ch[i].pin_oe <= 1'b0;
			end
			st_ff.plim <= `PWMC_PLIM_RST;
			st_ff.pcnt <= `PWMC_ZERO8;
			st_ff.sub <= `PWMC_ZERO2;
			st_ff.ps_cnt <= 6'h00;
			st_ff.t_on <= 1'b0;
			st_ff.sleep <= 1'b0;
			st_ff.ps_sel <= 2'h0;
			st_ff.reload <= 1'b0;
			st_ff.ack <= 1'b0;
			st_ff.rdat <= `PWMC_ZERO32;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign wb_ack_o = st_ff.ack;
	assign wb_dat_o = st_ff.rdat;

	generate
		for (genvar g = 0; g < NUM_CH; g++) begin : g_pin
			assign pwm_pin_o[g] = st_ff.ch[g].pin;
			assign pwm_pin_oe_o[g] = st_ff.ch[g].pin_oe;
		end
	endgenerate

endmodule : pwmc_top

// [test/pwmc_top_monitor.sv]
`timescale 1ns/1ps
`include "pwmc_defines.svh"
module pwmc_top_monitor (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic [1:0] pwm_pin_o,
	input wire logic [1:0] pwm_pin_oe_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire req = wb_cyc_i && wb_stb_i;
	wire rd = wb_ack_o && !wb_we_i;
	a_ack_next: assert property (req && !wb_ack_o |=> wb_ack_o) else $error("ack late");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
	a_ack_cause: assert property (!req |=> !wb_ack_o) else $error("ack without request");
	a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000) else $error("upper data");
	a_ctrl_unimpl: assert property (rd && (wb_adr_i == `PWMC_ADR_CTRL0 || wb_adr_i == `PWMC_ADR_CTRL1)
		|-> wb_dat_o[3:0] == 4'h0) else $error("control low bits");
	a_dcl_unimpl: assert property (rd && (wb_adr_i == `PWMC_ADR_DCL0 || wb_adr_i == `PWMC_ADR_DCL1)
		|-> wb_dat_o[5:0] == 6'h00) else $error("duty low bits");
	a_oe_from_write: assert property ($past(!rst_i) && $changed(pwm_pin_oe_o[0]) |->
		$past(wb_ack_o && wb_cyc_i && wb_we_i && wb_sel_i[0] && wb_adr_i == `PWMC_ADR_CTRL0, 2)
		&& pwm_pin_oe_o[0] == $past(wb_dat_i[6], 2)) else $error("drive enable change");
	a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> pwm_pin_o == 2'h0 && pwm_pin_oe_o == 2'h0)
		else $error("outputs in reset");
	c_read: cover property (rd);
	c_oe_on: cover property ($rose(pwm_pin_oe_o[0]));
	c_pin1: cover property ($rose(pwm_pin_o[1]));
endmodule : pwmc_top_monitor

// [test/pwmc_load.sv]
`timescale 1ns/1ps
module pwmc_load (
	input wire logic [1:0] pin_i,
	input wire logic [1:0] oe_i,
	output logic [1:0] level_o
);
	// load has a pull-down, so a released pin reads low
	assign level_o = oe_i & pin_i;
endmodule : pwmc_load

// [test/pwmc_top_test.sv]
`timescale 1ns/1ps
`include "pwmc_defines.svh"
module pwmc_top_test;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0000_0000;
	logic [31:0] dat_o;
	logic [31:0] rd;
	logic ack;
	logic [1:0] pin;
	logic [1:0] oe;
	logic [1:0] lvl;
	int mismatches = 0;
	int num_checks = 0;
	initial forever #5 clk_i = ~clk_i;
	pwmc_top pwmc_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.pwm_pin_o(pin), .pwm_pin_oe_o(oe));
	pwmc_load pwmc_load_i (.pin_i(pin), .oe_i(oe), .level_o(lvl));
	task complete_run;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk
	// classic cycle, held until ack; one idle cycle after
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic s);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= {3'h0, s};
		wdat <= {24'h00_0000, d};
		@(posedge clk_i);
		while (ack !== 1'b1) @(posedge clk_i);
		rd = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask : bus
	task automatic t_regs;
		bus(1'b1, `PWMC_ADR_CTRL0, 8'hFF, 1'b1);
		bus(1'b0, `PWMC_ADR_CTRL0, 8'h00, 1'b1);
		chk(rd & 32'h0000_00DF, 32'h0000_00D0, "ctrl");
		bus(1'b1, `PWMC_ADR_DCH0, 8'hA5, 1'b1);
		bus(1'b1, `PWMC_ADR_DCH0, 8'h11, 1'b0);
		bus(0, `PWMC_ADR_DCH0, 8'h00, 1'b1);
		chk(rd, 32'h0000_00A5, "dch");
		bus(1'b1, `PWMC_ADR_DCL0, 8'hFF, 1'b1);
		bus(1'b0, `PWMC_ADR_DCL0, 8'h00, 1'b1);
		chk(rd, 32'h0000_00C0, "dcl");
		bus(1'b0, 8'h40, 8'h00, 1'b1);
		chk(rd, 32'h0000_0000, "unmapped");
		rst_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		bus(1'b0, `PWMC_ADR_CTRL0, 8'h00, 1'b1);
		chk(rd, 32'h0000_0000, "ctrl reset");
		bus(1'b0, `PWMC_ADR_DCH0, 8'h00, 1'b1);
		chk(rd, 32'h0000_00A5, "dch kept");
	endtask : t_regs
	// period is 16 clocks with limit 3, so 32 clocks hold two pulses
	task automatic t_wave(input int c, input logic [9:0] d, input logic [7:0] ctl, input int exp);
		int act = 0;
		bus(1'b1, c ? `PWMC_ADR_DCH1 : `PWMC_ADR_DCH0, d[9:2], 1'b1);
		bus(1'b1, c ? `PWMC_ADR_DCL1 : `PWMC_ADR_DCL0, {d[1:0], 6'h00}, 1'b1);
		bus(1'b1, c ? `PWMC_ADR_CTRL1 : `PWMC_ADR_CTRL0, ctl, 1'b1);
		repeat (40) @(posedge clk_i);
		repeat (32) begin
			@(posedge clk_i);
			act += (lvl[c] === ~ctl[4]);
		end
		chk(act, exp, "active clocks");
	endtask : t_wave
	task automatic t_sleep;
		logic [1:0] p;
		int chg = 0;
		bus(1'b1, `PWMC_ADR_TCFG, 8'h03, 1'b1);
		@(posedge clk_i);
		p = pin;
		repeat (40) begin
			@(posedge clk_i);
			chg += (pin !== p);
		end
		chk(chg, 0, "sleep");
		bus(1'b1, `PWMC_ADR_TCFG, 8'h01, 1'b1);
	endtask : t_sleep
	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_regs();
		bus(1'b1, `PWMC_ADR_PLIM, 8'h03, 1'b1);
		bus(1'b1, `PWMC_ADR_TCFG, 8'h01, 1'b1);
		t_wave(0, 10'h006, 8'hC0, 12);
		t_wave(0, 10'h006, 8'h50, 0);
		t_wave(1, 10'h000, 8'hC0, 0);
		t_wave(0, 10'h3FF, 8'hC0, 32);
		bus(1'b0, `PWMC_ADR_CTRL0, 8'h00, 1'b1);
		chk(rd & 32'h0000_0020, 32'h0000_0020, "level view");
		t_wave(1, 10'h00A, 8'hD0, 20);
		t_sleep();
		bus(1'b1, `PWMC_ADR_CTRL0, 8'h80, 1'b1);
		@(posedge clk_i);
		chk(lvl[0], 1'b0, "released");
		complete_run();
	end
	initial begin
		#200000;
		mismatches++;
		complete_run();
	end
endmodule : pwmc_top_test
bind pwmc_top pwmc_top_monitor pwmc_top_monitor_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pwm_pin_o(pwm_pin_o), .pwm_pin_oe_o(pwm_pin_oe_o));
